/* hdl/slave_end.sv */
`timescale 1ns/1ps
// depth must be a power of two, the pointers wrap freely
module byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b0;
        end else begin
            count <= next_count;
            in_ready <= next_count != (AW+1)'(DEPTH);
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) mem[wr_ptr] <= in_data;
    end
endmodule

module slave_end import slave_link_pkg::*; #(
    parameter int BIT_CYCLES_P = BIT_CYCLES,
    parameter int MS_CYCLES_P = MS_CYCLES,
    parameter int FIFO_DEPTH = FIFO_WORDS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    serial_link_if.device link,
    input wire logic [7:0] own_addr,
    input wire logic [7:0] send_wait_ms,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_we,
    output logic reg_re,
    input wire logic [15:0] reg_rdata
);
    typedef enum logic [2:0] {
        st_rx, st_check, st_write, st_read, st_gap, st_send
    } state_t;

    state_t state;
    logic [7:0] rbuf [REQ_MAX];
    logic [15:0] words [MAX_REGS];
    logic [5:0] rx_len;
    logic [15:0] rx_crc;
    logic over;
    logic [7:0] rsp_fc;
    logic is_err;
    logic [7:0] ecode;
    logic [15:0] start;
    logic [4:0] cnt;
    logic bcast_q;
    logic [4:0] idx;
    logic [31:0] gap_cnt;
    logic [5:0] tx_idx;
    logic [5:0] tx_len;
    logic [15:0] tx_crc;

    // request path, the fifo stalls the master while we answer
    wire [8:0] f_data;
    wire f_valid;
    wire f_pop = f_valid && state == st_rx;
    byte_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) rx_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_data({link.m_last, link.m_data}),
        .in_valid(link.m_valid),
        .in_ready(link.m_ready),
        .out_data(f_data),
        .out_valid(f_valid),
        .out_ready(state == st_rx)
    );

    wire [7:0] fc = rbuf[1];
    wire [15:0] q_start = {rbuf[2], rbuf[3]};
    wire [15:0] q_cnt = {rbuf[4], rbuf[5]};
    wire bcast = rbuf[0] == ADDR_BCAST;
    // own address or broadcast, crc residue zero
    wire frame_ok = !over && rx_len >= LEN_MIN && rx_crc == 16'h0000
                    && (rbuf[0] == own_addr || bcast);
    wire cnt_ok = q_cnt != 16'h0000 && q_cnt <= 16'(MAX_REGS);
    wire [5:0] wr_len = LEN_WRITE_BASE + {q_cnt[4:0], 1'b0};
    wire rd_ok = cnt_ok && rx_len == LEN_READ_REQ;
    // byte count twice the register count
    wire wr_ok = cnt_ok && rbuf[6] == {q_cnt[6:0], 1'b0} && rx_len == wr_len;
    // broadcast limited to run and frequency registers
    wire bc_ok = (q_start == REG_RUN && q_cnt <= 16'h0002)
                 || (q_start == REG_FREQ && q_cnt == 16'h0001);
    wire known_fc = fc == FC_READ || fc == FC_WRITE;

    wire [5:0] wpos = POS_WDATA + {idx, 1'b0};
    wire [31:0] gap_target = 32'(GAP_BITS * BIT_CYCLES_P)
                             + 32'(send_wait_ms) * 32'(MS_CYCLES_P);

    // reply byte selection for the next slot
    wire [5:0] n = tx_idx + 6'h01;
    wire [5:0] d_off = n - 6'h03;
    wire [3:0] wsel = d_off[4:1];
    wire [15:0] tx_after = crc16_byte(tx_crc, link.s_data);
    // error sets bit 7 of the function code
    wire [7:0] fc_out = is_err ? (rsp_fc | FC_ERR_BIT) : rsp_fc;
    // write reply echoes start and count
    wire [7:0] wr_body = n == 6'h02 ? start[15:8] :
                         n == 6'h03 ? start[7:0] :
                         n == 6'h04 ? 8'h00 : {3'b000, cnt};
    // bytecount then each word high byte first
    wire [7:0] rd_body = n == 6'h02 ? {2'b00, cnt, 1'b0} :
                         d_off[0] ? words[wsel][7:0] : words[wsel][15:8];
    wire [7:0] body = is_err ? ecode :
                      rsp_fc == FC_WRITE ? wr_body : rd_body;
    // crc low byte first, then high
    wire [7:0] byte_next = n == tx_len - 6'h02 ? tx_after[7:0] :
                           n == tx_len - 6'h01 ? tx_crc[15:8] :
                           n == 6'h01 ? fc_out : body;
    wire tx_fire = link.s_valid && link.s_ready;

    always_ff @(posedge core_clk) begin
        if (f_pop && rx_len < 6'(REQ_MAX)) rbuf[rx_len] <= f_data[7:0];
        // one 16-bit word per register read
        if (state == st_read && reg_re) words[4'(idx - 5'h01)] <= reg_rdata;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= st_rx;
            rx_len <= '0;
            rx_crc <= CRC_INIT;
            over <= 1'b0;
            rsp_fc <= '0;
            is_err <= 1'b0;
            ecode <= '0;
            start <= '0;
            cnt <= '0;
            bcast_q <= 1'b0;
            idx <= '0;
            gap_cnt <= '0;
            tx_idx <= '0;
            tx_len <= '0;
            tx_crc <= CRC_INIT;
            reg_addr <= '0;
            reg_wdata <= '0;
            reg_we <= 1'b0;
            reg_re <= 1'b0;
            link.s_data <= '0;
            link.s_valid <= 1'b0;
            link.s_last <= 1'b0;
        end else begin
            reg_we <= 1'b0;
            gap_cnt <= state == st_rx ? 32'h0 : gap_cnt + 32'h1;
            case (state)
                st_rx: begin
                    if (f_pop) begin
                        rx_crc <= crc16_byte(rx_crc, f_data[7:0]);
                        if (rx_len >= 6'(REQ_MAX)) over <= 1'b1;
                        if (rx_len != 6'h3f) rx_len <= rx_len + 6'h01;
                        if (f_data[8]) state <= st_check;
                    end
                end
                st_check: begin
                    rx_len <= '0;
                    rx_crc <= CRC_INIT;
                    over <= 1'b0;
                    rsp_fc <= fc;
                    start <= q_start;
                    cnt <= q_cnt[4:0];
                    bcast_q <= bcast;
                    idx <= '0;
                    is_err <= 1'b0;
                    if (!frame_ok) begin
                        state <= st_rx;
                    end else if (fc == FC_READ && rd_ok) begin
                        state <= bcast ? st_rx : st_read;
                    end else if (fc == FC_WRITE && wr_ok) begin
                        state <= (bcast && !bc_ok) ? st_rx : st_write;
                    end else if (bcast) begin
                        state <= st_rx;
                    end else begin
                        is_err <= 1'b1;
                        ecode <= known_fc ? ERR_DATA : ERR_FUNC;
                        state <= st_gap;
                    end
                end
                st_write: begin
                    reg_we <= 1'b1;
                    reg_addr <= start + 16'(idx);
                    reg_wdata <= {rbuf[wpos], rbuf[wpos + 6'h01]};
                    idx <= idx + 5'h01;
                    if (idx == cnt - 5'h01) begin
                        state <= bcast_q ? st_rx : st_gap;
                    end
                end
                st_read: begin
                    // walk the run one word per cycle
                    reg_re <= idx < cnt;
                    reg_addr <= start + 16'(idx);
                    if (idx == cnt) state <= st_gap;
                    else idx <= idx + 5'h01;
                end
                st_gap: begin
                    // turnaround before the first reply byte
                    if (gap_cnt >= gap_target) begin
                        tx_len <= is_err ? LEN_ERR :
                                  rsp_fc == FC_WRITE ? LEN_WRITE_RSP :
                                  LEN_ERR + {cnt, 1'b0};
                        tx_idx <= '0;
                        tx_crc <= CRC_INIT;
                        link.s_data <= own_addr;
                        link.s_valid <= 1'b1;
                        link.s_last <= 1'b0;
                        state <= st_send;
                    end
                end
                st_send: begin
                    if (tx_fire) begin
                        // crc covers all but the crc bytes
                        if (tx_idx < tx_len - 6'h02) tx_crc <= tx_after;
                        if (link.s_last) begin
                            link.s_valid <= 1'b0;
                            link.s_last <= 1'b0;
                            state <= st_rx;
                        end else begin
                            tx_idx <= n;
                            link.s_data <= byte_next;
                            link.s_last <= n == tx_len - 6'h01;
                        end
                    end
                end
                default: state <= st_rx;
            endcase
        end
    end
endmodule

/* shared/slave_link_pkg.sv */
// Contract
// - all fields travel as whole bytes
// - read asks at most 16 registers
// - read request: addr, 03h, start, count, crc
// - registers run consecutively from start register
// - every register holds one 16-bit word
// - read reply: addr, 03h, bytecount, words, crc
// - byte count equals twice register count
// - error reply five bytes, read gives 83h
// - failed write answers with function 90h
// - write carries at most 16 registers
// - write request: addr, 10h, start, count, bytes, data
// - write reply echoes start and count
// - broadcast address 00 writes registers 1, 2
// - broadcast never gets any reply
// - crc-16, poly 8005 reflected, init ffff
// - reply gap 24 bits plus wait
// - unsupported function answered with error reply
package slave_link_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
    localparam int BAUD = 9600;
    localparam int BIT_CYCLES = (CLK_HZ + BAUD - 1) / BAUD;
    localparam int GAP_BITS = 24;
    localparam int MASTER_GAP_MS = 10;
    localparam int MS_CYCLES = 1_000_000 / CLK_PERIOD_NS;
    localparam int RSP_TIMEOUT_MS = 100;
    localparam int MAX_REGS = 16;
    localparam int FIFO_WORDS = 16;
    localparam int REQ_MAX = 41;
    localparam int RSP_MAX = 37;
    localparam logic [5:0] LEN_MIN = 6'h04;
    localparam logic [5:0] LEN_ERR = 6'h05;
    localparam logic [5:0] LEN_READ_REQ = 6'h08;
    localparam logic [5:0] LEN_WRITE_RSP = 6'h08;
    localparam logic [5:0] LEN_WRITE_BASE = 6'h09;
    localparam logic [5:0] POS_WDATA = 6'h07;
    localparam logic [7:0] ADDR_BCAST = 8'h00;
    localparam logic [7:0] FC_READ = 8'h03;
    localparam logic [7:0] FC_WRITE = 8'h10;
    localparam logic [7:0] FC_ERR_BIT = 8'h80;
    localparam logic [7:0] ERR_FUNC = 8'h01;
    localparam logic [7:0] ERR_DATA = 8'h03;
    localparam logic [7:0] ERR_LOCAL = 8'hfe;
    localparam logic [7:0] ERR_TIMEOUT = 8'hff;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY_REV = 16'ha001;
    localparam logic [15:0] REG_RUN = 16'h0001;
    localparam logic [15:0] REG_FREQ = 16'h0002;

    // lsb first, so the reflected polynomial shifts right
    function automatic logic [15:0] crc16_byte(input logic [15:0] crc,
                                               input logic [7:0] data);
        logic [15:0] c;
        c = crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY_REV) : (c >> 1);
        end
        return c;
    endfunction
endpackage

/* shared/serial_link_if.sv */
`timescale 1ns/1ps
// m_* carries requests to the device, s_* carries replies back
interface serial_link_if;
    logic [7:0] m_data;
    logic m_valid;
    logic m_last;
    logic m_ready;
    logic [7:0] s_data;
    logic s_valid;
    logic s_last;
    logic s_ready;
    modport master(output m_data, m_valid, m_last, s_ready,
                   input m_ready, s_data, s_valid, s_last);
    modport device(input m_data, m_valid, m_last, s_ready,
                   output m_ready, s_data, s_valid, s_last);
endinterface

/* hdl/master_end.sv */
`timescale 1ns/1ps
module master_end import slave_link_pkg::*; #(
    parameter int BIT_CYCLES_P = BIT_CYCLES,
    parameter int MS_CYCLES_P = MS_CYCLES,
    parameter int TIMEOUT_CYCLES = RSP_TIMEOUT_MS * MS_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    serial_link_if.master link,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_slave,
    input wire logic [15:0] cmd_start,
    input wire logic [15:0] cmd_count,
    input wire logic [255:0] cmd_wdata,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic rsp_err,
    output logic [7:0] rsp_code,
    output logic [255:0] rsp_rdata,
    output logic [4:0] rsp_words
);
    typedef enum logic [2:0] {
        mt_idle, mt_send, mt_recv, mt_check, mt_gap
    } mstate_t;

    mstate_t state;
    logic [7:0] rbuf [RSP_MAX];
    logic [255:0] wdata;
    logic [7:0] slave;
    logic [7:0] fc;
    logic [15:0] start;
    logic [4:0] cnt;
    logic [5:0] tx_idx;
    logic [5:0] tx_len;
    logic [15:0] tx_crc;
    logic [5:0] rx_len;
    logic [15:0] rx_crc;
    logic [31:0] timer;

    wire cnt_ok = cmd_count != 16'h0000 && cmd_count <= 16'(MAX_REGS);
    wire [5:0] n = tx_idx + 6'h01;
    wire [5:0] d_off = n - POS_WDATA;
    wire [15:0] wd_word = wdata[{d_off[4:1], 4'h0} +: 16];
    wire [15:0] tx_after = crc16_byte(tx_crc, link.m_data);
    wire [7:0] body = n == 6'h01 ? fc :
                      n == 6'h02 ? start[15:8] :
                      n == 6'h03 ? start[7:0] :
                      n == 6'h04 ? 8'h00 :
                      n == 6'h05 ? {3'b000, cnt} :
                      n == 6'h06 ? {2'b00, cnt, 1'b0} :
                      d_off[0] ? wd_word[7:0] : wd_word[15:8];
    wire [7:0] byte_next = n == tx_len - 6'h02 ? tx_after[7:0] :
                           n == tx_len - 6'h01 ? tx_crc[15:8] : body;
    wire rx_fire = link.s_valid && link.s_ready;
    wire [5:0] rd_len = LEN_ERR + {cnt, 1'b0};
    wire rx_ok = rx_crc == 16'h0000 && rbuf[0] == slave;
    wire rd_bad = fc == FC_READ
                  && (rbuf[2] != {2'b00, cnt, 1'b0} || rx_len != rd_len);
    wire [31:0] gap_target = 32'(GAP_BITS * BIT_CYCLES_P)
                             + 32'(MASTER_GAP_MS * MS_CYCLES_P);

    always_ff @(posedge core_clk) begin
        if (rx_fire && rx_len < 6'(RSP_MAX)) rbuf[rx_len] <= link.s_data;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= mt_idle;
            wdata <= '0;
            slave <= '0;
            fc <= '0;
            start <= '0;
            cnt <= '0;
            tx_idx <= '0;
            tx_len <= '0;
            tx_crc <= CRC_INIT;
            rx_len <= '0;
            rx_crc <= CRC_INIT;
            timer <= '0;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_err <= 1'b0;
            rsp_code <= '0;
            rsp_rdata <= '0;
            rsp_words <= '0;
            link.m_data <= '0;
            link.m_valid <= 1'b0;
            link.m_last <= 1'b0;
            link.s_ready <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            timer <= timer + 32'h1;
            case (state)
                mt_idle: begin
                    cmd_ready <= 1'b1;
                    if (cmd_valid && cmd_ready) begin
                        if (!cnt_ok) begin
                            rsp_valid <= 1'b1;
                            rsp_err <= 1'b1;
                            rsp_code <= ERR_DATA;
                        end else begin
                            cmd_ready <= 1'b0;
                            slave <= cmd_slave;
                            fc <= cmd_write ? FC_WRITE : FC_READ;
                            start <= cmd_start;
                            cnt <= cmd_count[4:0];
                            wdata <= cmd_wdata;
                            tx_len <= cmd_write
                                ? LEN_WRITE_BASE + {cmd_count[4:0], 1'b0}
                                : LEN_READ_REQ;
                            tx_idx <= '0;
                            tx_crc <= CRC_INIT;
                            link.m_data <= cmd_slave;
                            link.m_valid <= 1'b1;
                            state <= mt_send;
                        end
                    end
                end
                mt_send: begin
                    if (link.m_valid && link.m_ready) begin
                        if (tx_idx < tx_len - 6'h02) tx_crc <= tx_after;
                        if (link.m_last) begin
                            link.m_valid <= 1'b0;
                            link.m_last <= 1'b0;
                            timer <= '0;
                            rx_len <= '0;
                            rx_crc <= CRC_INIT;
                            if (slave == ADDR_BCAST) begin
                                rsp_valid <= 1'b1;
                                rsp_err <= 1'b0;
                                rsp_code <= '0;
                                rsp_words <= cnt;
                                state <= mt_gap;
                            end else begin
                                link.s_ready <= 1'b1;
                                state <= mt_recv;
                            end
                        end else begin
                            tx_idx <= n;
                            link.m_data <= byte_next;
                            link.m_last <= n == tx_len - 6'h01;
                        end
                    end
                end
                mt_recv: begin
                    if (rx_fire) begin
                        rx_crc <= crc16_byte(rx_crc, link.s_data);
                        if (rx_len != 6'h3f) rx_len <= rx_len + 6'h01;
                        if (link.s_last) begin
                            link.s_ready <= 1'b0;
                            state <= mt_check;
                        end
                    end else if (timer >= 32'(TIMEOUT_CYCLES)) begin
                        link.s_ready <= 1'b0;
                        rsp_valid <= 1'b1;
                        rsp_err <= 1'b1;
                        rsp_code <= ERR_TIMEOUT;
                        timer <= '0;
                        state <= mt_gap;
                    end
                end
                mt_check: begin
                    rsp_valid <= 1'b1;
                    rsp_words <= cnt;
                    timer <= '0;
                    state <= mt_gap;
                    for (int i = 0; i < MAX_REGS; i++) begin
                        rsp_rdata[16*i +: 16] <= {rbuf[3+2*i], rbuf[4+2*i]};
                    end
                    if (!rx_ok || rx_len > 6'(RSP_MAX)) begin
                        rsp_err <= 1'b1;
                        rsp_code <= ERR_LOCAL;
                    end else if (rbuf[1] == (fc | FC_ERR_BIT)) begin
                        rsp_err <= 1'b1;
                        rsp_code <= rbuf[2];
                    end else if (rbuf[1] != fc || rd_bad) begin
                        rsp_err <= 1'b1;
                        rsp_code <= ERR_LOCAL;
                    end else begin
                        rsp_err <= 1'b0;
                        rsp_code <= '0;
                    end
                end
                mt_gap: begin
                    // 24 bit times plus 10 ms before next request
                    if (timer >= gap_target) state <= mt_idle;
                end
                default: state <= mt_idle;
            endcase
        end
    end
endmodule

/* tb/link_sva.sv */
`timescale 1ns/1ps
module link_sva #(
    parameter int BIT_CYCLES_P = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] m_data,
    input wire logic m_valid,
    input wire logic m_last,
    input wire logic m_ready,
    input wire logic [7:0] s_data,
    input wire logic s_valid,
    input wire logic s_last,
    input wire logic s_ready
);
    logic [5:0] s_idx, m_idx;
    logic [7:0] fc, bc;
    logic [11:0] gap;
    logic bcast;
    wire s_go = s_valid && s_ready;
    wire m_go = m_valid && m_ready;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // gap saturates so long idle never wraps
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {s_idx, m_idx, fc, bc, gap, bcast} <= '0;
        end else begin
            if (s_go) s_idx <= s_last ? 6'h00 : s_idx + 6'h01;
            if (s_go && s_idx == 6'h01) fc <= s_data;
            if (s_go && s_idx == 6'h02) bc <= s_data;
            if (m_go) m_idx <= m_last ? 6'h00 : m_idx + 6'h01;
            if (m_go && m_idx == 6'h00) bcast <= (m_data == 8'h00);
            if (m_go && m_last) gap <= '0;
            else if (gap != 12'hfff) gap <= gap + 12'h001;
        end
    end
    property p_m_hold; m_valid && !m_ready |=>
        m_valid && $stable(m_data) && $stable(m_last); endproperty
    a_m_hold: assert property (p_m_hold) else $error("req dropped");
    property p_s_hold; s_valid && !s_ready |=>
        s_valid && $stable(s_data) && $stable(s_last); endproperty
    a_s_hold: assert property (p_s_hold) else $error("rsp dropped");
    property p_fc; s_valid && s_idx == 6'h01 |->
        s_data inside {8'h03, 8'h10, 8'h83, 8'h90}; endproperty
    a_fc: assert property (p_fc) else $error("bad function");
    property p_bc; s_valid && s_idx == 6'h02 && fc == 8'h03 |->
        !s_data[0] && s_data inside {[8'h02:8'h20]}; endproperty
    a_bc: assert property (p_bc) else $error("bad byte count");
    property p_rd_len; s_go && s_last && fc == 8'h03 |->
        {2'b00, s_idx} == bc + 8'h04; endproperty
    a_rd_len: assert property (p_rd_len) else $error("read len");
    property p_wr_len; s_go && s_last && fc == 8'h10 |->
        s_idx == 6'h07; endproperty
    a_wr_len: assert property (p_wr_len) else $error("write len");
    property p_err_len; s_go && s_last && fc[7] |->
        s_idx == 6'h04; endproperty
    a_err_len: assert property (p_err_len) else $error("err len");
    property p_gap; $rose(s_valid) |->
        gap >= 24 * BIT_CYCLES_P; endproperty
    a_gap: assert property (p_gap) else $error("reply too early");
    property p_bcast; s_valid |-> !bcast; endproperty
    a_bcast: assert property (p_bcast) else $error("bcast reply");
    property p_min; m_go && m_last |-> m_idx >= 6'h03; endproperty
    a_min: assert property (p_min) else $error("short request");
    c_rd: cover property (s_go && s_last && fc == 8'h03);
    c_wr: cover property (s_go && s_last && fc == 8'h10);
    c_bcast: cover property (m_go && m_last && bcast);
endmodule

/* tb/serial_register_read_write_slave_bench.sv */
`timescale 1ns/1ps
module serial_register_read_write_slave_bench;
    logic core_clk = 0, rst_n = 0, cmd_valid = 0, cmd_write = 0;
    logic [7:0] cmd_slave = 0, rsp_code;
    logic [15:0] cmd_start = 0, cmd_count = 0, reg_addr, reg_wdata, reg_rdata;
    logic [255:0] cmd_wdata = 0, rsp_rdata;
    logic cmd_ready, rsp_valid, rsp_err, reg_we, reg_re;
    logic [4:0] rsp_words;
    logic [15:0] mem [0:63];
    logic [7:0] own_addr = 8'h05, send_wait_ms = 8'h02;
    int n_fail = 0, cmp_count = 0, cyc = 0, n_re = 0;
    serial_link_if link();
    master_end #(.BIT_CYCLES_P(4), .MS_CYCLES_P(8), .TIMEOUT_CYCLES(2000))
        u_master_end (.core_clk, .rst_n, .link, .cmd_valid, .cmd_write,
        .cmd_slave, .cmd_start, .cmd_count, .cmd_wdata, .cmd_ready,
        .rsp_valid, .rsp_err, .rsp_code, .rsp_rdata, .rsp_words);
    slave_end #(.BIT_CYCLES_P(4), .MS_CYCLES_P(8)) u_slave_end (.core_clk,
        .rst_n, .link, .own_addr, .send_wait_ms, .reg_addr,
        .reg_wdata, .reg_we, .reg_re, .reg_rdata);
    link_sva u_link_sva (.core_clk, .rst_n,
        .m_data(link.m_data), .m_valid(link.m_valid), .m_last(link.m_last),
        .m_ready(link.m_ready), .s_data(link.s_data), .s_valid(link.s_valid),
        .s_last(link.s_last), .s_ready(link.s_ready));
    initial forever #50 core_clk = ~core_clk;
    // store answers in the address cycle, where the slave samples it
    assign reg_rdata = mem[reg_addr[5:0]];
    always @(posedge core_clk) begin
        if (reg_we) mem[reg_addr[5:0]] <= reg_wdata;
        if (reg_re) n_re++;
    end
    task automatic wrap_up;
        $display("fails=%0d compares=%0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic run(input logic w, input logic [7:0] sl,
        input logic [15:0] st, input logic [15:0] n, input logic [31:0] wd);
        int t;
        @(posedge core_clk);
        {cmd_valid, cmd_write, cmd_slave, cmd_start} <= {1'b1, w, sl, st};
        cmd_count <= n;
        cmd_wdata <= {224'h0, wd};
        @(negedge core_clk);
        while (cmd_ready !== 1'b1) @(negedge core_clk);
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        for (t = 0; t < 5000 && rsp_valid !== 1'b1; t++) @(negedge core_clk);
        chk({15'h0, rsp_valid}, 16'h0001);
    endtask
    task automatic t_wr_rd;
        run(1'b1, 8'h05, 16'h0001, 16'h0002, 32'h1201_1200);
        chk({15'h0, rsp_err}, 16'h0000);
        chk(mem[1], 16'h1200);
        run(1'b0, 8'h05, 16'h0001, 16'h0002, 32'h0);
        chk({15'h0, rsp_err}, 16'h0000);
        chk(rsp_rdata[15:0], 16'h1200);
        chk(rsp_rdata[31:16], 16'h1201);
        chk({11'h0, rsp_words}, 16'h0002);
    endtask
    task automatic t_rd16;
        int r0;
        r0 = n_re;
        run(1'b0, 8'h05, 16'h0010, 16'h0010, 32'h0);
        chk(16'(n_re - r0), 16'h0010);
        chk(rsp_rdata[255:240], 16'ha01f);
        chk(rsp_rdata[15:0], 16'ha010);
        run(1'b0, 8'h05, 16'h0000, 16'h0011, 32'h0);
        chk({rsp_code, 7'h0, rsp_err}, 16'h0301);
    endtask
    task automatic t_bcast;
        run(1'b1, 8'h00, 16'h0005, 16'h0001, 32'h0aaa);
        run(1'b1, 8'h00, 16'h0002, 16'h0001, 32'h0bbb);
        chk({15'h0, rsp_err}, 16'h0000);
        run(1'b0, 8'h05, 16'h0002, 16'h0004, 32'h0);
        chk(rsp_rdata[15:0], 16'h0bbb);
        chk(rsp_rdata[63:48], 16'ha005);
    endtask
    task automatic t_other;
        run(1'b0, 8'h07, 16'h0001, 16'h0001, 32'h0);
        chk({rsp_code, 7'h0, rsp_err}, 16'hff01);
        @(posedge core_clk);
        own_addr <= 8'h07;
        run(1'b0, 8'h07, 16'h0001, 16'h0001, 32'h0);
        chk({rsp_code, 7'h0, rsp_err}, 16'h0000);
        chk(rsp_rdata[15:0], 16'h1200);
    endtask
    initial begin
        for (int i = 0; i < 64; i++) mem[i] = 16'ha000 + 16'(i);
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        t_wr_rd();
        t_rd16();
        t_bcast();
        t_other();
        wrap_up();
    end
endmodule
